// ### design/msf_consts.svh
// constants for the monitor status flag block
`ifndef MSF_CONSTS_SVH
`define MSF_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define MSF_IDX_PRIM      8'h41
`define MSF_IDX_SEC       8'h42
`define MSF_IDX_IRQ_ST    8'h44
`define MSF_IDX_IRQ_MASK  8'h45
// ----------------------------------------
// field positions
// ----------------------------------------
`define MSF_B_CORE        1
`define MSF_B_SUPPLY      2
`define MSF_B_REM1        4
`define MSF_B_LOCAL       5
`define MSF_B_REM2        6
`define MSF_B_SUMMARY     7
`define MSF_B_OVT         1
`define MSF_B_FAN_ONE_FAULT        2
`define MSF_B_SHARED      5
`define MSF_B_DIODE1      6
`define MSF_B_DIODE2      7
`define MSF_B_EV_PRIM     0
`define MSF_B_EV_SEC      1
// ----------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------
`define MSF_RST_PRIM      8'h00
`define MSF_RST_SEC       8'h00
`define MSF_RST_IRQ       2'h0
`define MSF_MASK_PRIM     8'h76
`define MSF_MASK_SEC      8'hFE
// ----------------------------------------
// bus responses
// ----------------------------------------
`define MSF_RESP_OKAY     2'h0
`define MSF_RESP_SLVERR   2'h2
`endif

// ### design/msf_pkg.sv
// types for the monitor status flag block
package msf_pkg;
   // shared pin function, gray along tach -> gpio -> timer
   typedef enum logic [1:0] {
      MSF_PIN_TACH  = 2'h0,
      MSF_PIN_GPIO  = 2'h1,
      MSF_PIN_TIMER = 2'h3
   } msf_pin_mode_t;
endpackage

// ### design/msf_status_flags.sv
// out-of-limit status flags with an axi4-lite register slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "msf_consts.svh"
module msf_status_flags #(
   parameter int ADDR_W = 12,
   parameter int RD_W   = 8,
   parameter int TACH_W = 16
) (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    nrst,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]       s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // readings and limits: core, supply, remote one, local, remote two
   input  wire logic [4:0][RD_W-1:0]    mon_reading,
   input  wire logic [4:0][RD_W-1:0]    mon_low_limit,
   input  wire logic [4:0][RD_W-1:0]    mon_high_limit,
   // fan tach counts and minimum-speed limits, fans one to four
   input  wire logic [3:0][TACH_W-1:0]  tach_count,
   input  wire logic [3:0][TACH_W-1:0]  tach_min_limit,
   // fan drive outputs running: fan_drive_one, two, fan_drive_three
   input  wire logic [2:0]              fan_drive_on,
   // overtemperature and diode conditions
   input  wire logic                    overtemp_exceeded,
   input  wire logic                    overtemp_below_hyst,
   input  wire logic                    overtemp_timer_over,
   input  wire logic [1:0]              diode_fault,
   // shared pin function and gpio drive
   input  wire logic [1:0]              shared_pin_mode,
   output logic                         shared_pin_o,
   output logic                         shared_pin_oe,
   // interrupt
   output logic                         irq
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == ADDR_W'({idx, 2'h0}));
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]        prim_r;
   logic [7:0]        prim_nxt;
   logic [7:0]        sec_r;
   logic [7:0]        sec_nxt;
   logic              gpio_level_r;
   logic [1:0]        irq_st_r;
   logic [1:0]        irq_st_nxt;
   logic [1:0]        irq_mask_r;
   logic              aw_have_r;
   logic              w_have_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   // ----------------------------------------
   // limit comparison
   // ----------------------------------------
   wire [4:0] viol;
   wire [3:0] fan_slow;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_mon
         assign viol[gi] = (mon_reading[gi] > mon_high_limit[gi]) ||
                           (mon_reading[gi] <= mon_low_limit[gi]);
      end
      // a minimum of all zeros or all ones disables the check
      for (gi = 0; gi < 4; gi++) begin : g_fan
         assign fan_slow[gi] = (tach_count[gi] > tach_min_limit[gi]) &&
                               (tach_min_limit[gi] != '0) &&
                               (tach_min_limit[gi] != '1);
      end
   endgenerate

   wire mode_gpio  = (shared_pin_mode == msf_pkg::MSF_PIN_GPIO);
   wire mode_timer = (shared_pin_mode == msf_pkg::MSF_PIN_TIMER);
   wire mode_tach  = !mode_gpio && !mode_timer;

   wire [2:0] fan_cond = fan_slow[2:0] & fan_drive_on;
   wire       fan4_cond = fan_slow[3] && fan_drive_on[2] && mode_tach;
   wire       timer_cond = overtemp_timer_over && mode_timer;
   wire       shared_cond = fan4_cond || timer_cond;

   wire [7:0] cond_p = {1'b0, viol[4], viol[3], viol[2],
                        1'b0, viol[1], viol[0], 1'b0};
   wire [7:0] cond_s = {diode_fault[1], diode_fault[0], shared_cond,
                        fan_cond, overtemp_exceeded, 1'b0};

   // a flag may clear on read only once its cause is gone
   wire [7:0] clrok_p = ~cond_p;
   wire [7:0] clrok_s = {~cond_s[7:2],
                         overtemp_below_hyst && !overtemp_exceeded,
                         1'b1};

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire ar_hs   = s_axi_arvalid && s_axi_arready;
   wire do_wr   = aw_have_r && w_have_r && !bvalid_r;
   wire rd_prim = ar_hs && hit(s_axi_araddr, `MSF_IDX_PRIM);
   wire rd_sec  = ar_hs && hit(s_axi_araddr, `MSF_IDX_SEC);
   wire rd_ist  = hit(s_axi_araddr, `MSF_IDX_IRQ_ST);
   wire rd_imsk = hit(s_axi_araddr, `MSF_IDX_IRQ_MASK);
   wire wr_prim = hit(awaddr_r, `MSF_IDX_PRIM);
   wire wr_sec  = hit(awaddr_r, `MSF_IDX_SEC);
   wire wr_ist  = hit(awaddr_r, `MSF_IDX_IRQ_ST);
   wire wr_imsk = hit(awaddr_r, `MSF_IDX_IRQ_MASK);
   wire wr_ok   = wr_prim || wr_sec || wr_ist || wr_imsk;
   wire rd_ok   = hit(s_axi_araddr, `MSF_IDX_PRIM) ||
                  hit(s_axi_araddr, `MSF_IDX_SEC) || rd_ist || rd_imsk;
   wire gpio_wr = do_wr && wr_sec && wstrb_r[0] && mode_gpio;

   // ----------------------------------------
   // flag registers
   // ----------------------------------------
   // in gpio mode the shared bit holds the pin level instead of a flag
   wire [7:0] sec_keep = mode_gpio ? ~(8'h01 << `MSF_B_SHARED) : 8'hFF;
   wire [7:0] sec_view = mode_gpio ?
                         (sec_r | (8'(gpio_level_r) << `MSF_B_SHARED)) : sec_r;
   wire [7:0] prim_view = (prim_r & `MSF_MASK_PRIM) |
                          (8'(|sec_view) << `MSF_B_SUMMARY);

   // set beats a clear landing in the same cycle
   assign prim_nxt = (cond_p | (prim_r & ~({8{rd_prim}} & clrok_p)))
                     & `MSF_MASK_PRIM;
   assign sec_nxt  = (cond_s | (sec_r & ~({8{rd_sec}} & clrok_s)))
                     & `MSF_MASK_SEC & sec_keep;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prim_r <= `MSF_RST_PRIM;
         sec_r  <= `MSF_RST_SEC;
      end else begin
         prim_r <= prim_nxt;
         sec_r  <= sec_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gpio_level_r <= 1'b0;
      end else if (gpio_wr) begin
         gpio_level_r <= wdata_r[`MSF_B_SHARED];
      end
   end

   assign shared_pin_o  = gpio_level_r;
   assign shared_pin_oe = mode_gpio;

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   wire [1:0] ev = {|(sec_nxt & ~sec_r), |(prim_nxt & ~prim_r)};
   wire [1:0] w1c = (do_wr && wr_ist && wstrb_r[0]) ? wdata_r[1:0] : 2'h0;
   assign irq_st_nxt = ev | (irq_st_r & ~w1c);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_st_r   <= `MSF_RST_IRQ;
         irq_mask_r <= `MSF_RST_IRQ;
      end else begin
         irq_st_r <= irq_st_nxt;
         if (do_wr && wr_imsk && wstrb_r[0]) begin
            irq_mask_r <= wdata_r[1:0];
         end
      end
   end

   // a set mask bit silences its source, so every source is live after reset
   assign irq = |(irq_st_r & ~irq_mask_r);

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_have_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         w_have_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (do_wr) begin
         w_have_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `MSF_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   // data is captured at the address edge, so the read-clear acts on what was seen
   wire [31:0] rd_mux = hit(s_axi_araddr, `MSF_IDX_PRIM) ? {24'h0, prim_view} :
                        hit(s_axi_araddr, `MSF_IDX_SEC)  ? {24'h0, sec_view}  :
                        rd_ist  ? {30'h0, irq_st_r}   :
                        rd_imsk ? {30'h0, irq_mask_r} : 32'h0;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= `MSF_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_ok ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_prim_read;
      rd_prim;
   endsequence
   sequence s_prim_data;
      s_axi_rvalid;
   endsequence
   sequence s_sec_read;
      rd_sec;
   endsequence

   chk_core_flag_set: assert property (viol[0] |=> prim_r[1])
      else $error("core rail flag not set");
   chk_supply_flag_set: assert property (viol[1] |=> prim_r[2])
      else $error("supply rail flag not set");
   chk_rem1_flag_set: assert property (viol[2] |=> prim_r[4])
      else $error("remote one flag not set");
   chk_local_flag_set: assert property (viol[3] |=> prim_r[5])
      else $error("local temp flag not set");
   chk_rem2_flag_set: assert property (viol[4] |=> prim_r[6])
      else $error("remote two flag not set");

   // read-clear, summary and flag-set checks, the read ones built from the read sequences
   chk_read_keeps_flag: assert property (
      (s_prim_read and prim_r[4] && viol[2]) |=> prim_r[4])
      else $error("active flag cleared by read");
   chk_read_clears_gone: assert property (
      (s_prim_read and prim_r[2] && !viol[1]) |=> !prim_r[2])
      else $error("subsided flag not cleared by read");
   chk_summary_or: assert property (
      s_prim_read ##1 s_prim_data |-> s_axi_rdata[7] == (|$past(sec_view)))
      else $error("summary bit differs from secondary or");
   chk_ovt_hyst_hold: assert property (
      (s_sec_read and sec_r[1] && !overtemp_below_hyst) |=> sec_r[1])
      else $error("overtemp cleared above hysteresis");
   chk_ovt_read_clear: assert property (
      (s_sec_read and sec_r[1] && overtemp_below_hyst && !overtemp_exceeded) |=> !sec_r[1])
      else $error("overtemp kept below hysteresis");
   chk_fan_one_set: assert property (
      (fan_slow[0] && fan_drive_on[0]) |=> sec_r[2])
      else $error("fan one fault not set");
   chk_fan_drive_off: assert property (
      (!fan_drive_on[0] && !sec_r[2]) |=> !sec_r[2])
      else $error("fan one flag set with drive off");
   chk_fan4_tach: assert property (
      (mode_tach && fan_slow[3] && fan_drive_on[2]) |=> sec_r[5])
      else $error("fan four fault not set");
   chk_fan4_drive_off: assert property (
      (mode_tach && !fan_drive_on[2] && !sec_r[5]) |=> !sec_r[5])
      else $error("fan four flag set with drive three off");
   chk_gpio_level: assert property (
      gpio_wr |=> shared_pin_o == $past(wdata_r[5]) ##1 shared_pin_o == $past(shared_pin_o))
      else $error("gpio write not on pin");
   chk_gpio_read_back: assert property (
      (s_sec_read and mode_gpio && !sec_r[5]) |=> s_axi_rdata[5] == $past(gpio_level_r))
      else $error("gpio level not read back");
   chk_timer_set: assert property (timer_cond |=> sec_r[5])
      else $error("timer flag not set");
   chk_diode_one_set: assert property (diode_fault[0] |=> sec_r[6])
      else $error("diode one fault not shown");
   chk_diode_set: assert property (diode_fault[1] |=> sec_r[7] && prim_view[7])
      else $error("diode two fault not shown");

   // boundaries: equal to the low limit violates, equal to the high limit does not
   chk_low_equal_set: assert property (
      (mon_reading[1] == mon_low_limit[1]) |=> prim_r[2])
      else $error("supply flag not set at its low limit");
   chk_high_equal_quiet: assert property (
      (mon_reading[0] == mon_high_limit[0] && mon_reading[0] > mon_low_limit[0] &&
       !prim_r[1]) |=> !prim_r[1])
      else $error("core flag set at its high limit");
   chk_tach_edge: assert property (
      (tach_count[1] == tach_min_limit[1]) |-> !fan_slow[1])
      else $error("fan fault at equal count");
   chk_fan_two_slow: assert property (
      (tach_count[1] > tach_min_limit[1] && tach_min_limit[1] != '0 &&
       tach_min_limit[1] != '1 && fan_drive_on[1]) |=> sec_r[3])
      else $error("fan two fault not set above its minimum");
   chk_reserved_zero: assert property (
      ((prim_r & ~`MSF_MASK_PRIM) == 8'h00) && sec_r[0] == 1'b0)
      else $error("reserved bit set");

endmodule // msf_status_flags
`default_nettype wire

// ### sim/msf_host_model.sv
// host model: axi4-lite master that serves one request at a time
`timescale 1ns/1ps
`default_nettype none
module msf_host_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // request side, req is a one-cycle pulse while idle
   input  wire logic        req,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   output logic             done,
   output logic [31:0]      rdata,
   output logic [1:0]       resp,
   // axi4-lite master, named after the slave pins it faces
   output logic [11:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [11:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} <= '0;
         {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
         {done, rdata, resp} <= '0;
      end else begin
         done <= 1'b0;
         if (req) begin
            s_axi_awvalid <= wr;
            s_axi_wvalid  <= wr;
            s_axi_bready  <= wr;
            s_axi_arvalid <= !wr;
            s_axi_rready  <= !wr;
            s_axi_awaddr  <= addr;
            s_axi_araddr  <= addr;
            s_axi_wdata   <= wdata;
            s_axi_wstrb   <= 4'hF;
         end
         // released payloads are inverted so a late sample cannot pass
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~s_axi_wdata;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~s_axi_araddr;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bready <= 1'b0;
            resp         <= s_axi_bresp;
            done         <= 1'b1;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rready <= 1'b0;
            resp         <= s_axi_rresp;
            rdata        <= s_axi_rdata;
            done         <= 1'b1;
         end
      end
   end
endmodule // msf_host_model
`default_nettype wire

// ### sim/msf_status_flags_test.sv
// self-checking bench for the monitor status flag block
`timescale 1ns/1ps
`default_nettype none
`include "msf_consts.svh"
module msf_status_flags_test;
   // ------------------------------
   // signals and tables
   // ------------------------------
   typedef struct {int k; logic [1:0] mode; logic [7:0] p; logic [7:0] s;} msf_row_t;
   localparam logic [11:0] A_P = {2'h0, `MSF_IDX_PRIM, 2'h0};
   localparam logic [11:0] A_S = {2'h0, `MSF_IDX_SEC, 2'h0};
   localparam logic [11:0] A_I = {2'h0, `MSF_IDX_IRQ_ST, 2'h0};
   localparam logic [11:0] A_M = {2'h0, `MSF_IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] ADR [4] = '{A_P, A_S, A_I, A_M};
   localparam logic [1:0]  OK = `MSF_RESP_OKAY;
   localparam logic [1:0]  ERR = `MSF_RESP_SLVERR;
   logic             sys_clk, nrst, req, wr, done, irq, pin_o, pin_oe;
   logic [11:0]      q_addr, s_axi_awaddr, s_axi_araddr;
   logic [31:0]      q_wdata, q_rdata, s_axi_wdata, s_axi_rdata;
   logic [1:0]       q_resp, s_axi_bresp, s_axi_rresp, pmode, dio;
   logic [3:0]       s_axi_wstrb;
   logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic             s_axi_rvalid, s_axi_rready, ovt_ex, ovt_hy, tmo;
   logic [4:0][7:0]  rdg;
   logic [3:0][15:0] tc;
   logic [2:0]       fan_on;
   int               n_fail = 0, check_count = 0, cyc = 0;
   msf_row_t rows [13] = '{'{0, 2'h0, 8'h02, 8'h00}, '{1, 2'h0, 8'h04, 8'h00},
      '{2, 2'h0, 8'h10, 8'h00}, '{3, 2'h0, 8'h20, 8'h00}, '{4, 2'h0, 8'h40, 8'h00},
      '{5, 2'h0, 8'h80, 8'h02}, '{6, 2'h0, 8'h80, 8'h04}, '{7, 2'h0, 8'h80, 8'h08},
      '{8, 2'h0, 8'h80, 8'h10}, '{9, 2'h0, 8'h80, 8'h20}, '{10, 2'h0, 8'h80, 8'h40},
      '{11, 2'h0, 8'h80, 8'h80}, '{12, msf_pkg::MSF_PIN_TIMER, 8'h80, 8'h20}};

   msf_status_flags u_msf_status_flags (
      .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mon_reading(rdg),
      .mon_low_limit({5{8'h10}}), .mon_high_limit({5{8'h80}}), .tach_count(tc),
      .tach_min_limit({4{16'h0100}}), .fan_drive_on(fan_on), .overtemp_exceeded(ovt_ex),
      .overtemp_below_hyst(ovt_hy), .overtemp_timer_over(tmo), .diode_fault(dio),
      .shared_pin_mode(pmode), .shared_pin_o(pin_o), .shared_pin_oe(pin_oe), .irq);
   msf_host_model u_msf_host_model (
      .sys_clk, .nrst, .req, .wr, .addr(q_addr), .wdata(q_wdata), .done, .rdata(q_rdata),
      .resp(q_resp), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   // the model answers whenever the slave does, so only a bounded wait here
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wr <= w;
      q_addr <= a;
      q_wdata <= d;
      req <= 1'b1;
      @(posedge sys_clk);
      req <= 1'b0;
      // done is read before this edge's updates, so it is the settled pulse
      do begin
         @(posedge sys_clk);
         n++;
      end while (done !== 1'b1 && n < 50);
      check("bus answer", {31'h0, done}, 32'h1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bus(1'b0, a, 32'h0);
      check("read data", q_rdata, d);
      check("read resp", {30'h0, q_resp}, {30'h0, r});
   endtask
   task automatic wt(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bus(1'b1, a, d);
      check("write resp", {30'h0, q_resp}, {30'h0, r});
   endtask
   task automatic cond(input int k, input logic on);
      case (k)
         0, 2, 4: rdg[k] <= on ? 8'h81 : 8'h40;
         1, 3:    rdg[k] <= on ? 8'h10 : 8'h40;
         5: begin
            ovt_ex <= on;
            ovt_hy <= !on;
         end
         6, 7, 8, 9: tc[k-6] <= on ? 16'h0101 : 16'h0080;
         10, 11:  dio[k-10] <= on;
         default: tmo <= on;
      endcase
   endtask
   // ------------------------------
   // clock, timeout and main sequence
   // ------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         $display("unexpected timeout after %0d cycles", cyc);
         print_verdict();
      end
   end
   initial begin
      {req, wr, ovt_ex, tmo, dio, q_addr, q_wdata, nrst} = '0;
      ovt_hy = 1'b1;
      rdg = {5{8'h40}};
      tc = {4{16'h0080}};
      fan_on = 3'b111;
      pmode = msf_pkg::MSF_PIN_TACH;
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) rd(ADR[i], 32'h0, OK);
      foreach (rows[i]) begin
         @(posedge sys_clk);
         pmode <= rows[i].mode;
         cond(rows[i].k, 1'b1);
         repeat (3) @(posedge sys_clk);
         cond(rows[i].k, 1'b0);
         repeat (2) @(posedge sys_clk);
         rd(A_P, {24'h0, rows[i].p}, OK);
         rd(A_S, {24'h0, rows[i].s}, OK);
         rd(A_P, 32'h0, OK);
         rd(A_S, 32'h0, OK);
      end
      // core high and fan two minimum met exactly, supply one above its low limit, and fan faults with their drives off
      pmode <= msf_pkg::MSF_PIN_TACH;
      rdg[0] <= 8'h80;
      rdg[1] <= 8'h11;
      tc <= {16'h0101, 16'h0080, 16'h0100, 16'h0101};
      fan_on <= 3'b010;
      repeat (3) @(posedge sys_clk);
      rd(A_P, 32'h0, OK);
      rd(A_S, 32'h0, OK);
      rdg <= {5{8'h40}};
      tc <= {4{16'h0080}};
      fan_on <= 3'b111;
      @(posedge sys_clk);
      cond(2, 1'b1);
      repeat (3) @(posedge sys_clk);
      rd(A_P, 32'h10, OK);
      rd(A_P, 32'h10, OK);
      cond(2, 1'b0);
      rd(A_P, 32'h10, OK);
      rd(A_P, 32'h0, OK);
      cond(5, 1'b1);
      repeat (3) @(posedge sys_clk);
      ovt_ex <= 1'b0;
      rd(A_P, 32'h80, OK);
      rd(A_S, 32'h02, OK);
      rd(A_S, 32'h02, OK);
      ovt_hy <= 1'b1;
      rd(A_S, 32'h02, OK);
      rd(A_S, 32'h0, OK);
      pmode <= msf_pkg::MSF_PIN_GPIO;
      wt(A_S, 32'h20, OK);
      check("pin drive", {30'h0, pin_oe, pin_o}, 32'h3);
      rd(A_S, 32'h20, OK);
      wt(A_S, 32'h0, OK);
      check("pin drive", {30'h0, pin_oe, pin_o}, 32'h2);
      pmode <= msf_pkg::MSF_PIN_TACH;
      wt(A_P, 32'hFF, OK);
      rd(A_P, 32'h0, OK);
      rd(12'h200, 32'h0, ERR);
      wt(12'h200, 32'h1, ERR);
      wt(A_I, 32'h3, OK);
      rd(A_I, 32'h0, OK);
      cond(3, 1'b1);
      @(posedge sys_clk);
      cond(3, 1'b0);
      rd(A_I, 32'h1, OK);
      check("irq", {31'h0, irq}, 32'h1);
      wt(A_M, 32'h1, OK);
      check("irq", {31'h0, irq}, 32'h0);
      wt(A_M, 32'h0, OK);
      check("irq", {31'h0, irq}, 32'h1);
      wt(A_I, 32'h1, OK);
      check("irq", {31'h0, irq}, 32'h0);
      rd(A_P, 32'h20, OK);
      print_verdict();
   end
endmodule // msf_status_flags_test
`default_nettype wire
